// File: ext_cfg_lock.v
// one-time configuration latch for the external regulator
// assumes i_por_n is the power-on reset only, never the soft reset
`include "ext_regulator_defs.vh"
module ext_cfg_lock (
  input  wire       i_ref_clk,
  input  wire       i_por_n,
  input  wire       i_wr,
  input  wire       i_normal,
  input  wire       i_sa_bit,
  input  wire       i_ls_bit,
  output reg  [1:0] o_cfg,
  output reg        o_fail
);
  reg [1:0] cfg_d;
  reg       fail_d;
  always @* begin
    cfg_d  = o_cfg;
    fail_d = 1'b0;
    if (i_wr) begin
      case (o_cfg)
        `CFG_NONE: begin
          if (i_ls_bit)
            cfg_d = `CFG_LOADSHARE;
          else if (i_sa_bit && i_normal)
            cfg_d = `CFG_STANDALONE;
        end
        `CFG_LOADSHARE: begin
          if (!i_ls_bit || i_sa_bit)
            fail_d = 1'b1;
        end
        default: cfg_d = o_cfg;
      endcase
    end
  end
  // only power loss clears the lock
  always @(posedge i_ref_clk) begin
    if (!i_por_n) begin
      o_cfg  <= `CFG_NONE;
      o_fail <= 1'b0;
    end else begin
      o_cfg  <= cfg_d;
      o_fail <= fail_d;
    end
  end
endmodule

// File: ext_host_model.sv
// host side: writes one control frame per call
// assumes bits {sa, ls, vsel, stop_keep, uv_keep}
module ext_host_model (
  input  wire logic       i_ref_clk,
  output logic            o_spi_wr,
  output logic [4:0]      o_bits
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_spi_wr = 1'b0;
    o_bits = 5'h00;
  end
  task automatic wr(input logic [4:0] v);
    @(posedge i_ref_clk);
    #1 o_spi_wr = 1'b1;
    o_bits = v;
    @(posedge i_ref_clk);
    #1 o_spi_wr = 1'b0;
    o_bits = ~v; // released bits carry junk
  endtask
endmodule

// File: ext_regulator_checker.sv
// assertions on the external regulator control ports
// assumes bind onto ext_regulator_config_control, one clock domain
module ext_regulator_checker (
  input wire       i_ref_clk,
  input wire       i_rst_n,
  input wire       i_por_n,
  input wire [2:0] i_chip_mode,
  input wire       i_spi_wr,
  input wire       i_standalone_enable,
  input wire       i_load_share_enable,
  input wire       o_ext_on,
  input wire [1:0] o_volt_sel,
  input wire [1:0] o_cfg,
  input wire       o_spi_fail,
  input wire       o_lp_stage
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n || !i_por_n);
  // first write after lock was cleared, skipping the cycle after reset
  sequence fresh_wr;
    o_cfg == 2'h0 && $past(i_rst_n) && !$past(i_spi_wr) && i_spi_wr;
  endsequence
  cfg_hold_a: assert property (o_cfg != 2'h0 |=> o_cfg == $past(o_cfg))
    else $error("configuration changed after lock");
  first_ls_a: assert property (fresh_wr ##0 i_load_share_enable |-> ##2 o_cfg == 2'h2)
    else $error("load share not locked");
  first_sa_a: assert property (fresh_wr ##0 (i_standalone_enable && !i_load_share_enable
    && i_chip_mode == 3'h1) |-> ##2 o_cfg == 2'h1) else $error("standalone not locked");
  ls_fail_a: assert property (o_cfg == 2'h2 && i_spi_wr && !i_load_share_enable |-> ##2 o_spi_fail)
    else $error("failure flag missing");
  sa_silent_a: assert property (o_cfg == 2'h1 && i_spi_wr |-> ##2 !o_spi_fail)
    else $error("failure flag raised");
  ls_volt_a: assert property (o_cfg == 2'h2 && $past(o_cfg) == 2'h2 |-> o_volt_sel == 2'h0)
    else $error("load share voltage wrong");
  mode_off_a: assert property ((i_chip_mode == 3'h0 || i_chip_mode == 3'h5
    || (o_cfg == 2'h2 && i_chip_mode == 3'h3))[*4] |-> !o_ext_on) else $error("output on in off mode");
  normal_stage_a: assert property (i_chip_mode == 3'h1 [*4] |-> !o_lp_stage)
    else $error("low power stage in normal");
  cover property (o_cfg == 2'h2 && o_spi_fail);
  cover property (o_cfg == 2'h1 && o_ext_on);
  cover property (o_cfg == 2'h2 && i_chip_mode == 3'h2 && o_ext_on);
endmodule
bind ext_regulator_config_control ext_regulator_checker u_ext_regulator_checker (.i_ref_clk, .i_rst_n, .i_por_n,
  .i_chip_mode, .i_spi_wr, .i_standalone_enable, .i_load_share_enable, .o_ext_on, .o_volt_sel, .o_cfg,
  .o_spi_fail, .o_lp_stage);

// File: ext_regulator_config_control.v
// external regulator configuration and on/off control
// assumes host writes land as one-cycle i_spi_wr strobes with bits valid
// Functional notes
// - standalone enable bit in normal mode, with the load-share bit clear, locks the standalone configuration.
// - load-share bit locks the load-sharing configuration.
// - after first selection, configuration never changes.
// - lock survives soft reset, cleared only by power loss.
// - standalone output is 3.3V for select 0, 1.8V for select 1.
// - load sharing ignores voltage select, fixed load-share voltage.
// - standalone: off in init/failsafe, set in normal, held in stop/sleep/restart.
// - load sharing follows main regulator per chip mode.
// - stop mode pauses load sharing, bit kept, resumes in normal.
// - stop-keep bit with load sharing keeps regulator on in stop.
// - supply undervoltage switches the regulator off.
// - regulator re-enables automatically when supply recovers.
// - keep-on bit keeps regulator enabled during undervoltage.
// - status flags reported on the second supply status word.
// - in stop, rising base-current trip adds the high-power stage.
// - falling base-current trip drops the high-power stage.
// - normal mode uses only the high-power stage.
// - undervoltage signalling only in standalone configuration.
// - change after load-share lock sets SPI failure, config kept.
// - change after standalone lock ignored silently, on/off still works.
`include "ext_regulator_defs.vh"
module ext_regulator_config_control (
  input  wire       i_ref_clk,
  input  wire       i_rst_n,
  input  wire       i_por_n,
  input  wire [2:0] i_chip_mode,
  input  wire       i_spi_wr,
  input  wire       i_standalone_enable,
  input  wire       i_load_share_enable,
  input  wire       i_ext_voltage_select,
  input  wire       i_load_share_stop_keep,
  input  wire       i_undervoltage_keep_on,
  input  wire       i_supply_uv,
  input  wire       i_main_reg_on,
  input  wire       i_base_rise_trip,
  input  wire       i_base_fall_trip,
  output reg        o_ext_on,
  output reg  [1:0] o_volt_sel,
  output reg  [1:0] o_cfg,
  output reg        o_spi_fail,
  output reg  [6:0] o_sup_stat_2,
  output reg        o_hp_stage,
  output reg        o_lp_stage
);
  wire [1:0] cfg;
  wire       cfg_fail;
  wire       hp;
  wire       lp;
  reg        sa_on_q;
  reg        sa_on_d;
  reg        ls_stop_q;
  reg        vsel_q;
  reg        uv_flag_q;
  reg        uv_keep_q;
  reg        want_on;
  reg        on_d;
  wire       normal = (i_chip_mode == `MODE_NORMAL);

  ext_cfg_lock u_lock (
    .i_ref_clk (i_ref_clk),
    .i_por_n   (i_por_n),
    .i_wr      (i_spi_wr),
    .i_normal  (normal),
    .i_sa_bit  (i_standalone_enable),
    .i_ls_bit  (i_load_share_enable),
    .o_cfg     (cfg),
    .o_fail    (cfg_fail)
  );

  ext_stage_sel u_stage (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_active    (o_ext_on),
    .i_normal    (normal),
    .i_rise_trip (i_base_rise_trip),
    .i_fall_trip (i_base_fall_trip),
    .o_hp        (hp),
    .o_lp        (lp)
  );

  // standalone on/off request, only written in normal mode
  always @* begin
    sa_on_d = sa_on_q;
    if (i_spi_wr && normal && cfg != `CFG_LOADSHARE)
      sa_on_d = i_standalone_enable;
  end

  // mode-dependent target before undervoltage handling
  always @* begin
    want_on = 1'b0;
    case (cfg)
      `CFG_STANDALONE: begin
        case (i_chip_mode)
          `MODE_INIT:     want_on = 1'b0;
          `MODE_FAILSAFE: want_on = 1'b0;
          default:        want_on = sa_on_q;
        endcase
      end
      `CFG_LOADSHARE: begin
        case (i_chip_mode)
          `MODE_NORMAL:  want_on = 1'b1;
          `MODE_RESTART: want_on = i_main_reg_on;
          `MODE_STOP:    want_on = ls_stop_q;
          default:       want_on = 1'b0;
        endcase
      end
      default: want_on = 1'b0;
    endcase
    on_d = want_on && (!i_supply_uv || uv_keep_q);
  end

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sa_on_q      <= 1'b0;
      ls_stop_q    <= 1'b0;
      vsel_q       <= 1'b0;
      uv_flag_q    <= 1'b0;
      uv_keep_q    <= 1'b0;
      o_ext_on     <= 1'b0;
      o_volt_sel   <= `VOUT_3V3;
      o_cfg        <= `CFG_NONE;
      o_spi_fail   <= 1'b0;
      o_sup_stat_2 <= 7'h00;
      o_hp_stage   <= 1'b0;
      o_lp_stage   <= 1'b0;
    end else begin
      sa_on_q <= sa_on_d;
      if (i_spi_wr) begin
        ls_stop_q <= i_load_share_stop_keep;
        vsel_q    <= i_ext_voltage_select;
        uv_keep_q <= i_undervoltage_keep_on;
      end
      uv_flag_q  <= i_supply_uv && (cfg == `CFG_STANDALONE);
      o_ext_on   <= on_d;
      if (cfg == `CFG_LOADSHARE)
        o_volt_sel <= `VOUT_3V3;
      else if (vsel_q)
        o_volt_sel <= `VOUT_1V8;
      else
        o_volt_sel <= `VOUT_3V3;
      o_cfg      <= cfg;
      o_spi_fail <= cfg_fail | (o_spi_fail & ~i_spi_wr);
      o_hp_stage <= hp;
      o_lp_stage <= lp;
      o_sup_stat_2[`ST_ON] <= o_ext_on;
      o_sup_stat_2[`ST_UV] <= uv_flag_q;
      o_sup_stat_2[`ST_LS] <= (cfg == `CFG_LOADSHARE);
      o_sup_stat_2[`ST_SA] <= (cfg == `CFG_STANDALONE);
      o_sup_stat_2[`ST_HP] <= hp;
      o_sup_stat_2[`ST_LP] <= lp;
      o_sup_stat_2[`ST_W] <= 1'b0;
    end
  end
endmodule

// File: ext_regulator_config_control_tb_top.sv
// testbench for the external regulator control block
// assumes host model drives frames, bench drives mode and supply
module ext_regulator_config_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] SA = 5'h10, LS = 5'h08, VS = 5'h04, SK = 5'h02, UK = 5'h01;
  logic clk = 0, rst_n = 0, por_n = 0, uv = 0, mon = 1, rise = 0, fall = 1;
  logic [2:0] md = 3'h0;
  wire wr, on, f, hp, lp;
  wire [4:0] b;
  wire [1:0] vs, cfg;
  wire [6:0] st;
  int bad_count = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  ext_host_model u_ext_host_model (.i_ref_clk(clk), .o_spi_wr(wr), .o_bits(b));
  ext_regulator_config_control u_ext_regulator_config_control (.i_ref_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n),
    .i_chip_mode(md), .i_spi_wr(wr), .i_standalone_enable(b[4]), .i_load_share_enable(b[3]),
    .i_ext_voltage_select(b[2]), .i_load_share_stop_keep(b[1]), .i_undervoltage_keep_on(b[0]), .i_supply_uv(uv),
    .i_main_reg_on(mon), .i_base_rise_trip(rise), .i_base_fall_trip(fall), .o_ext_on(on), .o_volt_sel(vs),
    .o_cfg(cfg), .o_spi_fail(f), .o_sup_stat_2(st), .o_hp_stage(hp), .o_lp_stage(lp));
  task chk(input string n, input logic [6:0] s, input logic [6:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task w(input logic [4:0] v);
    u_ext_host_model.wr(v);
    go(3);
  endtask
  task m(input logic [2:0] v);
    md = v;
    go(4);
  endtask
  task c3(input logic [1:0] c, input logic o, input logic fl);
    chk("cfg", cfg, c);
    chk("on", on, o);
    chk("fail", f, fl);
  endtask
  task pwr;
    por_n = 0;
    rst_n = 0;
    go(8);
    por_n = 1;
    rst_n = 1;
  endtask
  task t_sa;
    pwr();
    w(SA); c3(0, 0, 0);
    m(1); w(SA | VS); c3(1, 1, 0);
    chk("volt", vs, 1);
    chk("stat", st & 7'h0d, 7'h09);
    w(SA | LS); c3(1, 1, 0);
    w(0); c3(1, 0, 0);
    w(SA); chk("volt", vs, 0);
    uv = 1; go(4); chk("on", on, 0);
    uv = 0; go(4); chk("on", on, 1);
    w(SA | UK); uv = 1; go(4); chk("on", on, 1);
    uv = 0; m(2); chk("on", on, 1);
    rise = 1; fall = 0; go(4); chk("stage", {hp, lp}, 2'h3);
    rise = 0; fall = 1; go(4); chk("stage", {hp, lp}, 2'h1);
    m(1); chk("stage", {hp, lp}, 2'h2);
    m(5); chk("on", on, 0);
    rst_n = 0; go(1); rst_n = 1; go(4); chk("cfg", cfg, 1);
    $display("standalone test done");
  endtask
  task t_ls;
    pwr(); m(1);
    w(SA | LS | VS); c3(2, 1, 0);
    chk("volt", vs, 0);
    w(SA); c3(2, 1, 1);
    m(2); c3(2, 0, 1);
    m(1); c3(2, 1, 1);
    w(LS | SK); m(2); c3(2, 1, 0);
    m(3); c3(2, 0, 0);
    m(4); c3(2, 1, 0);
    mon = 0; go(4); chk("on", on, 0);
    mon = 1;
    $display("load share test done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    t_sa();
    t_ls();
    print_verdict();
  end
endmodule

// File: ext_regulator_defs.vh
// constants for the external regulator control block
// assumes inclusion by every design file of this block
`ifndef EXT_REGULATOR_DEFS_VH
`define EXT_REGULATOR_DEFS_VH
// chip mode codes on i_chip_mode
`define MODE_INIT      3'h0
`define MODE_NORMAL    3'h1
`define MODE_STOP      3'h2
`define MODE_SLEEP     3'h3
`define MODE_RESTART   3'h4
`define MODE_FAILSAFE  3'h5
// configuration states
`define CFG_NONE       2'h0
`define CFG_STANDALONE 2'h1
`define CFG_LOADSHARE  2'h2
// output voltage codes on o_volt_sel
`define VOUT_3V3       2'h0
`define VOUT_1V8       2'h1
// status word bit positions
`define ST_ON          0
`define ST_UV          1
`define ST_LS          2
`define ST_SA          3
`define ST_HP          4
`define ST_LP          5
`define ST_W           6
`endif

// File: ext_stage_sel.v
// low/high power stage selection from base-current comparators
// assumes comparator inputs already synchronous to i_ref_clk
`include "ext_regulator_defs.vh"
module ext_stage_sel (
  input  wire i_ref_clk,
  input  wire i_rst_n,
  input  wire i_active,
  input  wire i_normal,
  input  wire i_rise_trip,
  input  wire i_fall_trip,
  output reg  o_hp,
  output reg  o_lp
);
  reg hp_d;
  always @* begin
    hp_d = o_hp;
    if (!i_active)
      hp_d = 1'b0;
    else if (i_normal)
      hp_d = 1'b1;
    else if (i_rise_trip)
      hp_d = 1'b1;
    else if (i_fall_trip)
      hp_d = 1'b0;
  end
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_hp <= 1'b0;
      o_lp <= 1'b0;
    end else begin
      o_hp <= hp_d;
      o_lp <= i_active && !i_normal;
    end
  end
endmodule
